/* File: src/host_if_regs.svh */
/*
  Register offsets, field positions, reset values and fixed codes of the
  host interface block. Assumes inclusion by bare name from src/.
*/
`ifndef HOST_IF_REGS_SVH
`define HOST_IF_REGS_SVH

// register indices; byte address is four times the index
`define IDX_CPU_IF      6'h02
`define IDX_PORT2       6'h03
`define IDX_IRQ_STATUS  6'h04
`define IDX_IRQ_MASK    6'h05
`define IDX_MODE        6'h06

// field positions
`define BIT_IRQ_PIN_SEL 0
`define BIT_P2B6_VALUE  0
`define BIT_P2B6_OE     1
`define BIT_MODE_PAR    0
`define BIT_MODE_SER    1
`define BIT_MODE_ICP    2

// interrupt event bits
`define EV_PAR_READ     0
`define EV_PAR_WRITE    1
`define EV_SER_DONE     2
`define NUM_EVENTS      3

// reset values
`define RST_CPU_IF      1'h0
`define RST_PORT2       2'h0
`define RST_EVENTS      3'h0

// serial framing
`define SER_CNT_CMD     4'h7
`define SER_CNT_LAST    4'hF
`define SER_READ_BIT    7
`define MEM_AW          3
`define DATA_W          8

`endif

/* File: src/host_if_pkg.sv */
/*
  Types shared by the host interface block.
  Assumes host_if_regs.svh is compiled in the same unit.
*/
package host_if_pkg;
  typedef enum logic [1:0] {P_IDLE, P_READ, P_ACK} parState_t;
  typedef logic [7:0] byte_t;
endpackage : host_if_pkg

/* File: src/host_if_mem.sv */
/*
  Small byte store reached by the host over the parallel or serial port.
  Assumes one write and one read port, read data registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "host_if_regs.svh"
module host_if_mem
  import host_if_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  we,
  input  wire logic [`MEM_AW-1:0]    wrAddr,
  input  wire logic [`DATA_W-1:0]    wrData,
  input  wire logic [`MEM_AW-1:0]    rdAddr,
  output logic      [`DATA_W-1:0]    rdData
);
  byte_t store [2**`MEM_AW];

  always_ff @(posedge clk) begin
    if (we) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= store[rdAddr];
    end
  end
endmodule : host_if_mem
`default_nettype wire

/* File: src/host_interface_signals.sv */
/*
  Host-facing signal logic: parallel non-multiplexed port with address
  strobe and acknowledge, serial port on mosi/miso, steerable interrupt
  pin, and an APB register slave. Assumes inputs synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "host_if_regs.svh"
module host_interface_signals
  import host_if_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               interfaceSelLo,
  input  wire logic               interfaceSelHi,
  input  wire logic               rdStrobe_n,
  input  wire logic               wrStrobe_n,
  input  wire logic               addrValid,
  input  wire logic               hostRead,
  input  wire logic [`MEM_AW-1:0] hostAddr,
  input  wire logic [`DATA_W-1:0] hostDataIn,
  output logic      [`DATA_W-1:0] hostDataOut,
  output logic                    hostDataOe,
  output logic                    transferAck_nOut,
  output logic                    transferAck_nOe,
  input  wire logic               idleClkPol,
  input  wire logic               sclk,
  input  wire logic               serCs_n,
  input  wire logic               mosi,
  output logic                    misoOut,
  output logic                    misoOe,
  output logic                    irqPrimOut,
  output logic                    irqPrimOe,
  output logic                    halfRefEn,
  output logic                    irqAltOut,
  output logic                    irqAltOe,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr
);
  function automatic logic regHit(input logic [7:0] a, input logic [5:0] idx);
    regHit = (a[7:2] == idx) && (a[1:0] == 2'h0);
  endfunction : regHit
  logic                    captured_r;
  logic                    modePar_r;
  logic                    modeSer_r;
  parState_t               parState_r;
  logic                    ackLow_r;
  logic                    readAcc_r;
  logic [`DATA_W-1:0]      hostData_r;
  logic                    irqPinSelect_r;
  logic [1:0]              port2_r;
  logic [`NUM_EVENTS-1:0]  status_r;
  logic [`NUM_EVENTS-1:0]  statusNxt;
  logic [`NUM_EVENTS-1:0]  mask_r;
  logic [`NUM_EVENTS-1:0]  events;
  logic [31:0]             prdata_r;
  logic                    effClkPrev_r;
  logic [3:0]              serCnt_r;
  logic [`DATA_W-1:0]      serShift_r;
  logic [`DATA_W-1:0]      serCmd_r;
  logic [`DATA_W-1:0]      serTx_r;
  logic                    loadTx_r;
  logic [`DATA_W-1:0]      memRdData;
  // apb decode
  wire apbWr    = psel && penable && pwrite;
  wire apbSetup = psel && !penable;
  wire hitCpu   = regHit(paddr, `IDX_CPU_IF);
  wire hitPort2 = regHit(paddr, `IDX_PORT2);
  wire hitStat  = regHit(paddr, `IDX_IRQ_STATUS);
  wire hitMask  = regHit(paddr, `IDX_IRQ_MASK);
  wire hitMode  = regHit(paddr, `IDX_MODE);
  wire anyHit   = hitCpu || hitPort2 || hitStat || hitMask || hitMode;
  wire [31:0] rdMux =
      hitCpu   ? {31'h0, irqPinSelect_r} :
      hitPort2 ? {30'h0, port2_r} :
      hitStat  ? {29'h0, status_r} :
      hitMask  ? {29'h0, mask_r} :
      hitMode  ? {29'h0, idleClkPol, modeSer_r, modePar_r} : 32'h0;
  // parallel port decode
  wire parTake  = modePar_r && (parState_r == P_IDLE) && addrValid;
  wire parWrite = parTake && !hostRead;
  wire parRead  = parTake && hostRead;
  // serial port decode
  wire effClk   = sclk ^ idleClkPol;
  wire serAct   = modeSer_r && !serCs_n;
  wire serLead  = serAct && effClk && !effClkPrev_r;
  wire serTrail = serAct && !effClk && effClkPrev_r;
  wire [`DATA_W-1:0] serByte = {serShift_r[`DATA_W-2:0], mosi};
  wire serCmdEnd = serLead && (serCnt_r == `SER_CNT_CMD);
  wire serEnd    = serLead && (serCnt_r == `SER_CNT_LAST);
  wire serWrite  = serEnd && !serCmd_r[`SER_READ_BIT];
  wire                memWe   = parWrite || serWrite;
  wire [`MEM_AW-1:0]  memWrA  = modeSer_r ? serCmd_r[`MEM_AW-1:0] : hostAddr;
  wire [`DATA_W-1:0]  memWrD  = modeSer_r ? serByte : hostDataIn;
  wire [`MEM_AW-1:0]  memRdA  = modeSer_r ? serByte[`MEM_AW-1:0] : hostAddr;
  host_if_mem u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .we     (memWe),
    .wrAddr (memWrA),
    .wrData (memWrD),
    .rdAddr (memRdA),
    .rdData (memRdData)
  );
  // mode caught at the first edge after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_r <= 1'b0;
      modePar_r  <= 1'b0;
      modeSer_r  <= 1'b0;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      modePar_r  <= interfaceSelHi && interfaceSelLo;
      modeSer_r  <= !(interfaceSelHi || interfaceSelLo || rdStrobe_n
                      || wrStrobe_n);
    end
  end
  // parallel access handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parState_r  <= P_IDLE;
      ackLow_r    <= 1'b0;
      readAcc_r   <= 1'b0;
      hostData_r  <= 8'h00;
    end else begin
      unique case (parState_r)
        P_IDLE: begin
          if (parWrite) begin
            ackLow_r   <= 1'b1;
            readAcc_r  <= 1'b0;
            parState_r <= P_ACK;
          end else if (parRead) begin
            parState_r <= P_READ;
          end
        end
        P_READ: begin
          hostData_r <= memRdData;
          readAcc_r  <= 1'b1;
          ackLow_r   <= 1'b1;
          parState_r <= P_ACK;
        end
        P_ACK: begin
          if (!addrValid) begin
            ackLow_r   <= 1'b0;
            readAcc_r  <= 1'b0;
            parState_r <= P_IDLE;
          end
        end
      endcase
    end
  end
  assign hostDataOut      = hostData_r;
  assign hostDataOe       = ackLow_r && readAcc_r;
  assign transferAck_nOut = !ackLow_r;
  assign transferAck_nOe  = modePar_r;
  // serial shifting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      effClkPrev_r <= 1'b0;
      serCnt_r     <= 4'h0;
      serShift_r   <= 8'h00;
      serCmd_r     <= 8'h00;
      serTx_r      <= 8'hFF;
      loadTx_r     <= 1'b0;
    end else begin
      effClkPrev_r <= effClk;
      loadTx_r     <= serCmdEnd && serByte[`SER_READ_BIT];
      if (!serAct) begin
        serCnt_r <= 4'h0;
        serTx_r  <= 8'hFF;
      end else begin
        if (serLead) begin
          serShift_r <= serByte;
          serCnt_r   <= serCnt_r + 4'h1;
        end
        if (serCmdEnd) serCmd_r <= serByte;
        if (loadTx_r) serTx_r <= memRdData;
        else if (serTrail) serTx_r <= {serTx_r[`DATA_W-2:0], 1'b1};
      end
    end
  end
  assign misoOut = 1'b0;
  assign misoOe  = serAct && !serTx_r[`DATA_W-1];
  // interrupt status, set wins over write-one-to-clear
  assign events[`EV_PAR_READ]  = parState_r == P_READ;
  assign events[`EV_PAR_WRITE] = parWrite;
  assign events[`EV_SER_DONE]  = serEnd;
  genvar g;
  generate
    for (g = 0; g < `NUM_EVENTS; g++) begin : g_stat
      assign statusNxt[g] = events[g] ||
          (status_r[g] && !(apbWr && hitStat && pwdata[g]));
    end
  endgenerate
  wire irqPending = |(status_r & mask_r);
  // apb registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPinSelect_r <= `RST_CPU_IF;
      port2_r        <= `RST_PORT2;
      mask_r         <= `RST_EVENTS;
      status_r       <= `RST_EVENTS;
      prdata_r       <= 32'h0;
    end else begin
      status_r <= statusNxt;
      if (apbSetup) prdata_r <= rdMux;
      if (apbWr && hitCpu) irqPinSelect_r <= pwdata[`BIT_IRQ_PIN_SEL];
      if (apbWr && hitPort2) port2_r <= pwdata[`BIT_P2B6_OE:`BIT_P2B6_VALUE];
      if (apbWr && hitMask) mask_r <= pwdata[`NUM_EVENTS-1:0];
    end
  end
  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !anyHit;
  // interrupt pin steering
  assign irqPrimOut = 1'b0;
  assign irqPrimOe  = !irqPinSelect_r && irqPending;
  assign halfRefEn  = irqPinSelect_r;
  assign irqAltOut  = irqPinSelect_r ? 1'b0 : port2_r[`BIT_P2B6_VALUE];
  assign irqAltOe   = irqPinSelect_r ? irqPending
                                     : port2_r[`BIT_P2B6_OE];
  sequence s_writeTaken;
    parWrite;
  endsequence
  sequence s_readTaken;
    parRead;
  endsequence
  property p_writeAck;
    @(posedge clk) disable iff (!rst_n) s_writeTaken |=> !transferAck_nOut;
  endproperty
  a_writeAck: assert property (p_writeAck) else $error("no write ack");
  property p_readAck;
    @(posedge clk) disable iff (!rst_n)
      s_readTaken |=> transferAck_nOut ##1 (!transferAck_nOut && hostDataOe);
  endproperty
  a_readAck: assert property (p_readAck) else $error("read ack timing");
  property p_ackRelease;
    @(posedge clk) disable iff (!rst_n)
      (!transferAck_nOut && !addrValid) |=> transferAck_nOut;
  endproperty
  a_ackRelease: assert property (p_ackRelease) else $error("ack held");
  property p_ackHold;
    @(posedge clk) disable iff (!rst_n)
      (!transferAck_nOut && addrValid) |=> !transferAck_nOut;
  endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack dropped early");
  property p_irqPrim;
    @(posedge clk) disable iff (!rst_n)
      (!irqPinSelect_r && irqPending) |-> (irqPrimOe && !halfRefEn);
  endproperty
  a_irqPrim: assert property (p_irqPrim) else $error("primary irq");
  property p_irqAlt;
    @(posedge clk) disable iff (!rst_n)
      irqPinSelect_r |-> (!irqPrimOe && halfRefEn && irqAltOe == irqPending);
  endproperty
  a_irqAlt: assert property (p_irqAlt) else $error("alternate irq");
  property p_misoOnlySerial;
    @(posedge clk) disable iff (!rst_n) misoOe |-> (modeSer_r && !serCs_n);
  endproperty
  a_misoOnlySerial: assert property (p_misoOnlySerial) else $error("miso");
  property p_serialSelect;
    @(posedge clk) disable iff (!rst_n)
      (!captured_r && !interfaceSelHi && !interfaceSelLo && !rdStrobe_n
       && !wrStrobe_n) |=> modeSer_r && !modePar_r;
  endproperty
  a_serialSelect: assert property (p_serialSelect) else $error("serial sel");
  property p_ackOnlyPar;
    @(posedge clk) disable iff (!rst_n) !modePar_r |-> transferAck_nOut;
  endproperty
  a_ackOnlyPar: assert property (p_ackOnlyPar) else $error("ack mode");
  property p_idlePolarity;
    @(posedge clk) disable iff (!rst_n)
      (serAct && (sclk == idleClkPol) && $past(sclk) != idleClkPol
       && $past(modeSer_r && !serCs_n)) |-> $stable(serCnt_r);
  endproperty
  a_idlePolarity: assert property (p_idlePolarity) else $error("polarity");
endmodule : host_interface_signals
`default_nettype wire

/* File: tb/host_cpu_model.sv */
/*
  host processor model: parallel strobe/acknowledge accesses and serial frames.
  assumes clk from the bench; acknowledge and miso lines have pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
`include "host_if_regs.svh"
module host_cpu_model
  import host_if_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               idleClkPol,
  input  wire logic               transferAck_nOut,
  input  wire logic               transferAck_nOe,
  input  wire logic [`DATA_W-1:0] hostDataOut,
  input  wire logic               hostDataOe,
  input  wire logic               misoOut,
  input  wire logic               misoOe,
  output var  logic               addrValid,
  output var  logic               hostRead,
  output var  logic [`MEM_AW-1:0] hostAddr,
  output var  logic [`DATA_W-1:0] hostDataIn,
  output var  logic               sclk,
  output var  logic               serCs_n,
  output var  logic               mosi,
  output var  logic               gotValid,
  output var  byte_t              gotByte,
  output var  logic               tmo
);
  // pulled-up open-drain lines
  wire ackLine  = transferAck_nOe ? transferAck_nOut : 1'b1;
  wire misoLine = misoOe ? misoOut : 1'b1;

  initial begin
    addrValid = 1'b0;
    hostRead = 1'b0;
    hostAddr = '0;
    hostDataIn = '0;
    sclk = 1'b0;
    serCs_n = 1'b1;
    mosi = 1'b0;
    gotValid = 1'b0;
    gotByte = '0;
    tmo = 1'b0;
  end

  task automatic waitAck(input logic lvl);
    int n;
    n = 0;
    while (ackLine !== lvl && n < 30) begin
      @(posedge clk);
      n++;
    end
    if (ackLine !== lvl) tmo <= 1'b1;
  endtask : waitAck

  task automatic parAcc(input logic rd, input logic [`MEM_AW-1:0] a, input byte_t d);
    @(posedge clk);
    addrValid <= 1'b1;
    hostRead <= rd;
    hostAddr <= a;
    hostDataIn <= d;
    waitAck(1'b0);
    if (rd) begin
      gotByte <= hostDataOe ? hostDataOut : ~hostDataOut;
      gotValid <= 1'b1;
    end
    addrValid <= 1'b0;
    hostDataIn <= ~d;
    @(posedge clk);
    gotValid <= 1'b0;
    waitAck(1'b1);
  endtask : parAcc

  task automatic serFrame(input byte_t cmd, input byte_t dat);
    logic [15:0] sh;
    byte_t       rdb;
    sh = {cmd, dat};
    rdb = 8'h00;
    // clock settles at its idle level before select falls
    @(posedge clk);
    sclk <= idleClkPol;
    @(posedge clk);
    serCs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      mosi <= sh[15-i];
      repeat (3) @(posedge clk);
      sclk <= ~idleClkPol;
      repeat (3) @(posedge clk);
      // readback bit stands from load or trailing edge until the next trailing edge
      if (i >= 7 && i < 15) rdb = {rdb[6:0], misoLine};
      sclk <= idleClkPol;
    end
    repeat (3) @(posedge clk);
    serCs_n <= 1'b1;
    mosi <= ~mosi;
    if (cmd[7]) begin
      gotByte <= rdb;
      gotValid <= 1'b1;
    end
    @(posedge clk);
    gotValid <= 1'b0;
  endtask : serFrame
endmodule : host_cpu_model
`default_nettype wire

/* File: tb/host_interface_signals_bench.sv */
/*
  bench: APB registers, parallel and serial host accesses, interrupt pins.
  assumes host_cpu_model as the far side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "host_if_regs.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failCount++; \
  $display("[FAIL] %0t mismatch %h vs %h", $time, g, e); end end
module host_interface_signals_bench
  import host_if_pkg::*;
;
  logic clk, rst_n, interfaceSelLo, interfaceSelHi, rdStrobe_n, wrStrobe_n, idleClkPol;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic addrValid, hostRead, hostDataOe, transferAck_nOut, transferAck_nOe;
  logic [`MEM_AW-1:0] hostAddr;
  logic [`DATA_W-1:0] hostDataIn, hostDataOut;
  logic sclk, serCs_n, mosi, misoOut, misoOe, gotValid, tmo;
  logic irqPrimOut, irqPrimOe, halfRefEn, irqAltOut, irqAltOe;
  byte_t gotByte, d, eb;
  logic [32:0] ea;
  logic [32:0] apbQ[$];
  byte_t byteQ[$];
  int failCount = 0;
  int checksDone = 0;

  host_interface_signals u_host_interface_signals (
    .clk(clk), .rst_n(rst_n), .interfaceSelLo(interfaceSelLo),
    .interfaceSelHi(interfaceSelHi), .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n),
    .addrValid(addrValid), .hostRead(hostRead), .hostAddr(hostAddr),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .transferAck_nOut(transferAck_nOut), .transferAck_nOe(transferAck_nOe),
    .idleClkPol(idleClkPol), .sclk(sclk), .serCs_n(serCs_n), .mosi(mosi),
    .misoOut(misoOut), .misoOe(misoOe), .irqPrimOut(irqPrimOut), .irqPrimOe(irqPrimOe),
    .halfRefEn(halfRefEn), .irqAltOut(irqAltOut), .irqAltOe(irqAltOe),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  host_cpu_model u_host_cpu_model (
    .clk(clk), .idleClkPol(idleClkPol), .transferAck_nOut(transferAck_nOut),
    .transferAck_nOe(transferAck_nOe), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .misoOut(misoOut), .misoOe(misoOe),
    .addrValid(addrValid), .hostRead(hostRead), .hostAddr(hostAddr),
    .hostDataIn(hostDataIn), .sclk(sclk), .serCs_n(serCs_n), .mosi(mosi),
    .gotValid(gotValid), .gotByte(gotByte), .tmo(tmo)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      ea = apbQ.pop_front();
      `CHK({pslverr, prdata}, ea)
    end
    if (gotValid) begin
      eb = byteQ.pop_front();
      `CHK(gotByte, eb)
    end
    if (tmo) begin
      failCount++;
      report_and_stop();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failCount++;
      report_and_stop();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apbQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic pins(input logic [3:0] e);
    @(negedge clk);
    `CHK({irqPrimOe, irqAltOe, irqAltOut, halfRefEn}, e)
  endtask : pins

  task automatic rst(input logic ser, input logic icp);
    rst_n <= 1'b0;
    interfaceSelLo <= ~ser;
    interfaceSelHi <= ~ser;
    rdStrobe_n <= ~ser;
    wrStrobe_n <= ~ser;
    idleClkPol <= icp;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(97866));
    rst(1'b0, 1'b0);
    @(negedge clk);
    `CHK(transferAck_nOe, 1'b1)
    rd(8'h18, 33'h1);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      u_host_cpu_model.parAcc(1'b0, 3'(i * 5), d);
      byteQ.push_back(d);
      u_host_cpu_model.parAcc(1'b1, 3'(i * 5), d);
    end
    rd(8'h10, 33'h3);
    pins(4'b0000);
    `CHK({irqPrimOut, misoOut}, 2'b00)
    apb(1'b1, 8'h14, 32'h1);
    pins(4'b1000);
    apb(1'b1, 8'h08, 32'h1);
    pins(4'b0101);
    apb(1'b1, 8'h10, 32'h1);
    pins(4'b0001);
    rd(8'h10, 33'h2);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'h3);
    pins(4'b0110);
    rd(8'h40, {1'b1, 32'h0});
    rst(1'b1, 1'b1);
    @(negedge clk);
    `CHK(transferAck_nOe, 1'b0)
    rd(8'h18, 33'h6);
    d = 8'($urandom);
    u_host_cpu_model.serFrame(8'h02, d);
    byteQ.push_back(d);
    u_host_cpu_model.serFrame(8'h82, 8'h00);
    rd(8'h10, 33'h4);
    rst(1'b1, 1'b0);
    rd(8'h18, 33'h2);
    d = 8'($urandom);
    u_host_cpu_model.serFrame(8'h05, d);
    byteQ.push_back(d);
    u_host_cpu_model.serFrame(8'h85, 8'h00);
    rd(8'h10, 33'h4);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : host_interface_signals_bench
`default_nettype wire
